/* File: logic/mdc_pkg.sv */
// Constants shared by the multidrop control block and its address filter.
// Assumes a 32-bit APB bus with word-aligned registers, four bytes per index.
package mdc_pkg;

    // =====================================================================
    // Widths
    localparam int unsigned MDC_DW = 32;
    localparam int unsigned MDC_AW = 14;
    localparam int unsigned MDC_IW = 12;
    localparam int unsigned MDC_CW = 9;
    localparam int unsigned MDC_BW = 8;
    localparam int unsigned MDC_SELW = 3;
    localparam int unsigned MDC_STW = 3;

    // =====================================================================
    // Register indices; byte address is four times the index
    localparam logic [MDC_IW-1:0] MDC_IDX_SEL = 12'hf42;
    localparam logic [MDC_IW-1:0] MDC_IDX_CTRL = 12'hf43;
    localparam logic [MDC_IW-1:0] MDC_IDX_CMP = 12'hf44;
    localparam logic [MDC_IW-1:0] MDC_IDX_STAT = 12'hf45;
    localparam logic [MDC_IW-1:0] MDC_IDX_IEN = 12'hf46;
    localparam logic [MDC_IW-1:0] MDC_IDX_ICLR = 12'hf47;
    localparam logic [MDC_IW-1:0] MDC_IDX_RXD = 12'hf48;

    // =====================================================================
    // Control field positions
    localparam int unsigned MDC_POL_HI = 7;
    localparam int unsigned MDC_EN_BIT = 6;
    localparam int unsigned MDC_POL_LO = 5;
    localparam int unsigned MDC_TX9_BIT = 4;
    localparam int unsigned MDC_DPOL_BIT = 3;
    localparam logic [MDC_SELW-1:0] MDC_SEL_CTRL = 3'h0;

    // Interrupt policy encodings
    localparam logic [1:0] MDC_POL_ALL = 2'h0;
    localparam logic [1:0] MDC_POL_ADDR = 2'h1;
    localparam logic [1:0] MDC_POL_MATCH = 2'h2;
    localparam logic [1:0] MDC_POL_FOLLOW = 2'h3;

    // Status bits and the receive data flag position
    localparam int unsigned MDC_ST_REQ = 0;
    localparam int unsigned MDC_ST_ADDR = 1;
    localparam int unsigned MDC_ST_OVR = 2;
    localparam int unsigned MDC_RXD_FULL = 9;

    // =====================================================================
    // Reset values
    localparam logic [MDC_BW-1:0] MDC_CTRL_RST = 8'h00;
    localparam logic [MDC_BW-1:0] MDC_CMP_RST = 8'h00;
    localparam logic [MDC_SELW-1:0] MDC_SEL_RST = 3'h0;
    localparam logic [MDC_STW-1:0] MDC_ST_RST = 3'h0;
    localparam logic [MDC_CW-1:0] MDC_RXD_RST = 9'h000;

endpackage

/* File: logic/mdc_rx_if.sv */
// Receive-path bundle between the control block and the address filter.
// Assumes both ends sit on the same pclk.
`timescale 1ns/1ps
interface mdc_rx_if;
    import mdc_pkg::*;
    logic rx_valid;
    logic [MDC_CW-1:0] rx_char;
    logic ninebit_en;
    logic [1:0] policy;
    logic [MDC_BW-1:0] cmp_addr;
    logic req;
    logic is_addr;
    logic [MDC_CW-1:0] out_char;
    modport ctl(output rx_valid, rx_char, ninebit_en, policy, cmp_addr, input req, is_addr, out_char);
    modport filt(input rx_valid, rx_char, ninebit_en, policy, cmp_addr, output req, is_addr, out_char);
endinterface

/* File: logic/mdc_filter.sv */
// Address/data classification and interrupt filtering of received characters.
// Assumes rx_valid is a one-cycle strobe with rx_char valid in the same cycle.
`timescale 1ns/1ps
module mdc_filter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Receive bundle
    mdc_rx_if.filt f
);
    import mdc_pkg::*;

    logic matched_r, matched_nxt;
    logic req_r, req_nxt;
    logic addr_r, addr_nxt;
    logic [MDC_CW-1:0] char_r, char_nxt;
    logic char_is_addr;
    logic char_hit;

    // =====================================================================
    // Filter
    always_comb begin
        char_is_addr = f.ninebit_en & f.rx_char[MDC_CW-1]; // [RULE10]
        char_hit = f.rx_char[MDC_BW-1:0] == f.cmp_addr;
        matched_nxt = matched_r;
        req_nxt = 1'b0;
        addr_nxt = 1'b0;
        char_nxt = char_r;
        if (f.rx_valid) begin
            char_nxt = f.rx_char;
            if (!f.ninebit_en) begin
                // Plain framing: every character is ordinary data
                req_nxt = 1'b1;
            end else if (char_is_addr) begin
                addr_nxt = 1'b1;
                matched_nxt = char_hit;
                case (f.policy)
                    MDC_POL_ALL: req_nxt = 1'b1; // [RULE1]
                    MDC_POL_ADDR: req_nxt = 1'b1; // [RULE2]
                    MDC_POL_MATCH: req_nxt = char_hit; // [RULE3]
                    default: req_nxt = 1'b0; // [RULE4]
                endcase
            end else begin
                case (f.policy)
                    MDC_POL_ALL: req_nxt = 1'b1; // [RULE1]
                    MDC_POL_ADDR: req_nxt = 1'b0; // [RULE2]
                    MDC_POL_MATCH: req_nxt = matched_r; // [RULE3]
                    default: req_nxt = matched_r; // [RULE4]
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            matched_r <= 1'b0;
            req_r <= 1'b0;
            addr_r <= 1'b0;
            char_r <= MDC_RXD_RST;
        end else begin
            matched_r <= matched_nxt;
            req_r <= req_nxt;
            addr_r <= addr_nxt;
            char_r <= char_nxt;
        end
    end

    assign f.req = req_r;
    assign f.is_addr = addr_r;
    assign f.out_char = char_r;

    // =====================================================================
    // Checks
    // Checker-side memory of the last address byte, kept apart from the filter state
    logic hit_seen_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_seen_r <= 1'b0;
        end else if (f.rx_valid && f.ninebit_en && f.rx_char[MDC_CW-1]) begin
            hit_seen_r <= f.rx_char[MDC_BW-1:0] == f.cmp_addr;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_nine(logic [1:0] p);
        f.rx_valid && f.ninebit_en && f.policy == p;
    endsequence
    sequence s_hit_addr;
        f.rx_valid && f.ninebit_en && f.rx_char[MDC_CW-1] && char_hit;
    endsequence
    sequence s_data;
        f.rx_valid && f.ninebit_en && !f.rx_char[MDC_CW-1];
    endsequence

    a_all_every_char: assert property (s_nine(MDC_POL_ALL) |=> f.req) // [RULE1]
        else $error("policy 00 missed a character");
    a_addr_only_quiet: assert property (s_nine(MDC_POL_ADDR) |=> f.req == f.is_addr) // [RULE2]
        else $error("policy 01 request not tied to address byte");
    a_match_hit_addr: assert property (s_nine(MDC_POL_MATCH) ##0 s_hit_addr |=> f.req) // [RULE3]
        else $error("policy 10 missed a matching address");
    a_match_data_follow: assert property (s_nine(MDC_POL_MATCH) ##0 s_data ##0 hit_seen_r |=> f.req) // [RULE3]
        else $error("policy 10 dropped data after matching address");
    a_follow_addr_quiet: assert property (s_nine(MDC_POL_FOLLOW) ##0 f.rx_char[MDC_CW-1] |=> !f.req) // [RULE4]
        else $error("policy 11 interrupted on an address byte");
    a_class_ninth: assert property (f.rx_valid |=> f.is_addr == ($past(f.ninebit_en) && f.out_char[MDC_CW-1])) // [RULE10]
        else $error("address classification wrong");
endmodule

/* File: logic/mdc_top.sv */
// Multidrop 9-bit control block: APB registers, receive interrupt filter,
// ninth-bit and driver-enable outputs for the serial core.
// Assumes the serial core strobes rx_valid per character and raises tx_busy while sending.
//
// Notes on behaviour
// RULE1: Policy 00 requests an interrupt for every data and address byte.
// RULE2: Policy 01 requests only on address bytes, never on data bytes.
// RULE3: Policy 10 requests on matching address, then each data byte until mismatch.
// RULE4: Policy 11 requests on data after a matching address; not on addresses.
// RULE5: Enable bit 6 switches 9-bit multidrop framing on or off.
// RULE6: Transmitted ninth bit carries the value of control bit 4.
// RULE7: Ninth-bit setting applies only while 9-bit framing is enabled.
// RULE8: Bit 3 zero gives active-high driver enable; one gives active-low.
// RULE9: Control register visible at its address only when register select is 000.
// RULE10: In 9-bit mode ninth bit 1 marks address byte, 0 marks data.
// RULE11: Senders set ninth bit 1 on address bytes and 0 on data bytes.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module mdc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mdc_pkg::MDC_AW-1:0] paddr,
    input wire logic [mdc_pkg::MDC_DW-1:0] pwdata,
    output logic [mdc_pkg::MDC_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver side of the serial core
    input wire logic rx_valid,
    input wire logic [mdc_pkg::MDC_CW-1:0] rx_char,
    // Transmitter side of the serial core
    input wire logic tx_busy,
    output logic frame_9bit,
    output logic tx_ninth_out,
    output logic drive_en_out,
    // Interrupt
    output logic irq
);
    import mdc_pkg::*;

    // =====================================================================
    // Bus decode
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic aligned;
    logic mapped;
    logic ctrl_vis;
    logic [MDC_IW-1:0] idx;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign idx = paddr[MDC_AW-1:2];
    assign aligned = paddr[1:0] == 2'b00;

    always_comb begin
        case (idx)
            MDC_IDX_SEL,
            MDC_IDX_CTRL,
            MDC_IDX_CMP,
            MDC_IDX_STAT,
            MDC_IDX_IEN,
            MDC_IDX_ICLR,
            MDC_IDX_RXD: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // =====================================================================
    // Register state
    logic [MDC_SELW-1:0] sel_r, sel_nxt;
    logic [MDC_BW-1:0] ctrl_r, ctrl_nxt;
    logic [MDC_BW-1:0] cmp_r, cmp_nxt;
    logic [MDC_STW-1:0] stat_r, stat_nxt;
    logic [MDC_STW-1:0] ien_r, ien_nxt;
    logic [MDC_CW-1:0] rxd_r, rxd_nxt;
    logic rxfull_r, rxfull_nxt;
    logic [MDC_STW-1:0] st_set;
    logic [MDC_STW-1:0] st_clr;
    logic rd_rxd;
    logic [1:0] policy;

    assign ctrl_vis = sel_r == MDC_SEL_CTRL; // [RULE9]

    mdc_rx_if rxl();

    assign policy = {ctrl_r[MDC_POL_HI], ctrl_r[MDC_POL_LO]};
    assign rxl.rx_valid = rx_valid;
    assign rxl.rx_char = rx_char;
    assign rxl.ninebit_en = ctrl_r[MDC_EN_BIT]; // [RULE5]
    assign rxl.policy = policy;
    assign rxl.cmp_addr = cmp_r;

    mdc_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .f(rxl.filt)
    );

    assign rd_rxd = rd && aligned && idx == MDC_IDX_RXD;

    always_comb begin
        sel_nxt = sel_r;
        ctrl_nxt = ctrl_r;
        cmp_nxt = cmp_r;
        ien_nxt = ien_r;
        st_clr = '0;
        if (wr && aligned) begin
            case (idx)
                MDC_IDX_SEL: sel_nxt = pwdata[MDC_SELW-1:0];
                MDC_IDX_CTRL: begin
                    // Other select values map foreign registers here; leave ours alone
                    if (ctrl_vis) begin
                        ctrl_nxt = pwdata[MDC_BW-1:0]; // [RULE9]
                    end
                end
                MDC_IDX_CMP: cmp_nxt = pwdata[MDC_BW-1:0];
                MDC_IDX_IEN: ien_nxt = pwdata[MDC_STW-1:0];
                MDC_IDX_ICLR: st_clr = pwdata[MDC_STW-1:0];
                default: sel_nxt = sel_r;
            endcase
        end
    end

    // Receive holding register; a read of it drains the full flag
    always_comb begin
        st_set = '0;
        st_set[MDC_ST_REQ] = rxl.req;
        st_set[MDC_ST_ADDR] = rxl.is_addr;
        st_set[MDC_ST_OVR] = rxl.req & rxfull_r & ~rd_rxd;
        rxd_nxt = rxl.req ? rxl.out_char : rxd_r;
        // A new character landing in the read cycle keeps the flag set
        rxfull_nxt = rxl.req | (rxfull_r & ~rd_rxd);
        stat_nxt = (stat_r & ~st_clr) | st_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= MDC_SEL_RST;
            ctrl_r <= MDC_CTRL_RST;
            cmp_r <= MDC_CMP_RST;
            stat_r <= MDC_ST_RST;
            ien_r <= MDC_ST_RST;
            rxd_r <= MDC_RXD_RST;
            rxfull_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            ctrl_r <= ctrl_nxt;
            cmp_r <= cmp_nxt;
            stat_r <= stat_nxt;
            ien_r <= ien_nxt;
            rxd_r <= rxd_nxt;
            rxfull_r <= rxfull_nxt;
        end
    end

    // =====================================================================
    // Bus answer: data is sampled in the setup cycle so the access phase
    // completes at its first edge with registered outputs
    logic [MDC_DW-1:0] rdata;
    logic [MDC_DW-1:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    always_comb begin
        rdata = '0;
        if (aligned) begin
            case (idx)
                MDC_IDX_SEL: rdata[MDC_SELW-1:0] = sel_r;
                MDC_IDX_CTRL: rdata[MDC_BW-1:0] = ctrl_vis ? ctrl_r : 8'h00; // [RULE9]
                MDC_IDX_CMP: rdata[MDC_BW-1:0] = cmp_r;
                MDC_IDX_STAT: rdata[MDC_STW-1:0] = stat_r;
                MDC_IDX_IEN: rdata[MDC_STW-1:0] = ien_r;
                MDC_IDX_RXD: begin
                    rdata[MDC_CW-1:0] = rxd_r;
                    rdata[MDC_RXD_FULL] = rxfull_r;
                end
                default: rdata = '0;
            endcase
        end
    end

    always_comb begin
        pready_nxt = setup;
        pslverr_nxt = setup & ~mapped;
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = pwrite ? '0 : rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // =====================================================================
    // Serial-core and interrupt outputs
    logic frame_r, frame_nxt;
    logic tx9_r, tx9_nxt;
    logic drv_r, drv_nxt;
    logic irq_r, irq_nxt;

    always_comb begin
        frame_nxt = ctrl_r[MDC_EN_BIT]; // [RULE5]
        // Forced low in plain framing so a stale setting never leaks out
        tx9_nxt = ctrl_r[MDC_EN_BIT] & ctrl_r[MDC_TX9_BIT]; // [RULE6] [RULE7]
        drv_nxt = tx_busy ^ ctrl_r[MDC_DPOL_BIT]; // [RULE8]
        irq_nxt = |(stat_r & ien_r);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_r <= 1'b0;
            tx9_r <= 1'b0;
            drv_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            frame_r <= frame_nxt;
            tx9_r <= tx9_nxt;
            drv_r <= drv_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign frame_9bit = frame_r;
    assign tx_ninth_out = tx9_r;
    assign drive_en_out = drv_r;
    assign irq = irq_r;

    // =====================================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl_write;
        wr && aligned && idx == MDC_IDX_CTRL;
    endsequence

    a_frame_follows_en: assert property (##1 frame_9bit == $past(ctrl_r[MDC_EN_BIT])) // [RULE5]
        else $error("framing output does not follow enable bit");
    a_ninth_sent: assert property (ctrl_r[MDC_EN_BIT] && ctrl_r[MDC_TX9_BIT] |=> tx_ninth_out) // [RULE6]
        else $error("ninth bit not driven from control");
    a_ninth_gated: assert property (!ctrl_r[MDC_EN_BIT] |=> !tx_ninth_out) // [RULE7]
        else $error("ninth bit leaked with framing off");
    a_drive_polarity: assert property (tx_busy && !ctrl_r[MDC_DPOL_BIT] ##1 tx_busy && !ctrl_r[MDC_DPOL_BIT]
        |-> drive_en_out) // [RULE8]
        else $error("driver enable not active high");
    a_drive_low_pol: assert property (tx_busy && ctrl_r[MDC_DPOL_BIT] |=> !drive_en_out) // [RULE8]
        else $error("driver enable not active low");
    a_select_gate: assert property (s_ctrl_write ##0 !ctrl_vis |=> $stable(ctrl_r)) // [RULE9]
        else $error("control written while hidden");
    a_select_write: assert property (s_ctrl_write ##0 ctrl_vis |=> ctrl_r == $past(pwdata[MDC_BW-1:0])) // [RULE9]
        else $error("control write lost while visible");
    a_hidden_read: assert property (setup && !pwrite && aligned && idx == MDC_IDX_CTRL && !ctrl_vis
        |=> prdata == '0) // [RULE9]
        else $error("hidden control register was readable");
    a_irq_level: assert property (rxl.req && ien_r[MDC_ST_REQ] |-> ##2 irq)
        else $error("enabled event did not raise interrupt");
    a_answer_time: assert property (setup |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");
endmodule

/* File: tb/mdc_node_model.sv */
// Partner model: another node on the multidrop line, seen through the serial core.
// Assumes one bench process calls its tasks; all changes land just after pclk rises.
`timescale 1ns/1ps
module mdc_node_model (
    // Clock
    input wire logic pclk,
    // Core strobes toward the block
    output logic rx_valid,
    output logic [mdc_pkg::MDC_CW-1:0] rx_char,
    output logic tx_busy
);
    import mdc_pkg::*;
    initial begin
        rx_valid = 1'b0;
        rx_char = 9'h000;
        tx_busy = 1'b0;
    end
    // =====================================================================
    // Character delivery
    task automatic send_char(input logic is_addr, input logic [MDC_BW-1:0] b);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_char <= {is_addr, b};
        @(posedge pclk);
        rx_valid <= 1'b0;
        // Stale character is inverted so nothing can latch it by accident
        rx_char <= ~{is_addr, b};
    endtask
    task automatic set_busy(input logic b);
        @(posedge pclk);
        tx_busy <= b;
    endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the multidrop control block over APB.
// Assumes APB answers within 16 cycles and the node model standing in for the serial core.
`timescale 1ns/1ps
module testbench;
    import mdc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite;
    logic [MDC_AW-1:0] paddr;
    logic [MDC_DW-1:0] pwdata, prdata, rdata;
    logic pready, pslverr, rx_valid, tx_busy, frame_9bit, tx_ninth_out, drive_en_out, irq, err;
    logic [MDC_CW-1:0] rx_char;
    int errors, tests_run;
    logic [7:0] seq_b [7] = '{8'h55, 8'h11, 8'h22, 8'h66, 8'h33, 8'h55, 8'h44};
    logic [6:0] seq_a = 7'b0101001;
    logic [6:0] exp_req [4] = '{7'b1111111, 7'b0101001, 7'b1100111, 7'b1000110};
    mdc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_char(rx_char), .tx_busy(tx_busy), .frame_9bit(frame_9bit),
        .tx_ninth_out(tx_ninth_out), .drive_en_out(drive_en_out), .irq(irq));
    mdc_node_model u_node (.pclk(pclk), .rx_valid(rx_valid), .rx_char(rx_char), .tx_busy(tx_busy));
    // =====================================================================
    // Clock, reset and watchdog
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end
    // =====================================================================
    // Compare and report
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic test_end(input string name);
        $display("Test %s done, errors so far %0d", name, errors);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // =====================================================================
    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic wr, input logic [MDC_IW-1:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Look on the falling edge so the rising edge's own update cannot race the check
        @(negedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(negedge pclk);
        end
        if (n == 16) begin
            errors++;
            $display("ERROR %0t no pready", $time);
        end
        rdata = prdata;
        err = pslverr;
        // The access completes at this rising edge; only then is the request released
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [MDC_IW-1:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rd_chk(input logic [MDC_IW-1:0] idx, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, idx, 32'h0);
        check_word(rdata, exp);
        check_bit(err, exp_err);
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask
    // =====================================================================
    // Tests
    initial begin
        errors = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(MDC_IDX_CTRL, 32'h0000_0000, 1'b0);
        check_bit(frame_9bit, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        check_bit(err, 1'b1);
        test_end("reset_and_map");
        // Control reachable only with select 000
        wr(MDC_IDX_SEL, 32'h1);
        wr(MDC_IDX_CTRL, 32'hff);
        rd_chk(MDC_IDX_CTRL, 32'h0, 1'b0);
        wr(MDC_IDX_SEL, 32'h0);
        rd_chk(MDC_IDX_CTRL, 32'h0, 1'b0);
        wr(MDC_IDX_CTRL, 32'h5a);
        rd_chk(MDC_IDX_CTRL, 32'h5a, 1'b0);
        test_end("select");
        // Ninth bit and framing enable
        wr(MDC_IDX_CTRL, 32'h50);
        settle();
        check_bit(frame_9bit, 1'b1);
        check_bit(tx_ninth_out, 1'b1);
        wr(MDC_IDX_CTRL, 32'h10);
        settle();
        check_bit(frame_9bit, 1'b0);
        check_bit(tx_ninth_out, 1'b0);
        test_end("ninth_bit");
        // Driver-enable polarity, both levels of busy
        u_node.set_busy(1'b1);
        settle();
        check_bit(drive_en_out, 1'b1);
        wr(MDC_IDX_CTRL, 32'h08);
        settle();
        check_bit(drive_en_out, 1'b0);
        u_node.set_busy(1'b0);
        settle();
        check_bit(drive_en_out, 1'b1);
        test_end("drive_polarity");
        // Policy filtering over one address/data sequence
        wr(MDC_IDX_CMP, 32'h55);
        for (int p = 0; p < 4; p++) begin
            wr(MDC_IDX_CTRL, {24'h0, p[1], 1'b1, p[0], 5'h00});
            for (int i = 0; i < 7; i++) begin
                wr(MDC_IDX_ICLR, 32'h7);
                u_node.send_char(seq_a[i], seq_b[i]);
                settle();
                apb(1'b0, MDC_IDX_STAT, 32'h0);
                check_bit(rdata[MDC_ST_REQ], exp_req[p][i]);
            end
        end
        // Plain framing: an address-flagged char is data and still requests
        wr(MDC_IDX_CTRL, 32'h20);
        wr(MDC_IDX_ICLR, 32'h7);
        u_node.send_char(1'b1, 8'h77);
        settle();
        apb(1'b0, MDC_IDX_STAT, 32'h0);
        check_bit(rdata[MDC_ST_REQ], 1'b1);
        // Plain char is no address; the holding register was never drained, so overrun is set too
        check_word(rdata, 32'h0000_0005);
        rd_chk(MDC_IDX_RXD, 32'h0000_0377, 1'b0);
        rd_chk(MDC_IDX_RXD, 32'h0000_0177, 1'b0);
        test_end("policies");
        // Interrupt raise, mask, unmask, clear
        wr(MDC_IDX_IEN, 32'h1);
        settle();
        check_bit(irq, 1'b1);
        wr(MDC_IDX_IEN, 32'h0);
        settle();
        check_bit(irq, 1'b0);
        wr(MDC_IDX_IEN, 32'h1);
        settle();
        check_bit(irq, 1'b1);
        wr(MDC_IDX_ICLR, 32'h7);
        settle();
        check_bit(irq, 1'b0);
        test_end("interrupt");
        wrap_up();
    end
endmodule
